// >>> rtl/rpc_pkg.sv
// Operation
// [R1] Writing 1 to a port's soft-reset bit returns that port's repeater logic to its power-on state; the bit resets to 0.
// [R2] At 100 Mbit/s the preamble start delay field times preamble regeneration from the arrival of carrier sense.
// [R3] The delay field is a 3-bit count of extra master-clock cycles, 000 meaning none and 111 meaning seven.
// [R4] The delay field resets to binary 100.
// [R5] At 10 Mbit/s the delay field is ignored and has no effect on preamble timing.
// [R6] Backplane-to-PHY data passes only while transmit enable is 1, and a change waits until port activity ends.
// [R7] PHY-to-backplane data passes only while receive enable is 1, and a change waits until port activity ends.
// [R8] Autopartition disable set to 1 stops the port's autopartition machine; 0 lets it run.
// [R9] At 10 Mbit/s the receive-valid-present bit says whether the PHY supplies a receive data valid signal.
package rpc_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [31:0] RPC_PORT0_CONTROL_ADDR  = 32'he0012020;
    localparam logic [31:0] RPC_PORT0_CONFIG_A_ADDR = 32'he0012024;
    localparam logic [31:0] RPC_PORT1_CONTROL_ADDR  = 32'he0012220;
    localparam logic [31:0] RPC_PORT1_CONFIG_A_ADDR = 32'he0012224;
    localparam int          RPC_PORTS               = 2;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int         RPC_SOFT_RESET_BIT      = 0;
    localparam int         RPC_DELAY_LSB           = 12;
    localparam int         RPC_RX_VALID_BIT        = 9;
    localparam int         RPC_TX_EN_BIT           = 8;
    localparam int         RPC_RX_EN_BIT           = 7;
    localparam int         RPC_AUTOPART_DIS_BIT    = 6;
    localparam logic [2:0] RPC_DELAY_RESET         = 3'h4;
    localparam logic       RPC_FLAG_RESET          = 1'b0;

    typedef enum logic {
        RPC_IDLE = 1'b0,
        RPC_WAIT = 1'b1
    } rpc_state_t;
endpackage

// >>> rtl/rpc_port.sv
`timescale 1ns/1ps
module rpc_port (
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire logic       soft_rst,
    input  wire logic       speed_100,
    input  wire logic       crs_pin,
    input  wire logic       bp_active,
    input  wire logic [2:0] delay,
    input  wire logic       tx_en_cfg,
    input  wire logic       rx_en_cfg,
    output logic            preamble_start,
    output logic            tx_path_en,
    output logic            rx_path_en
);
    logic                crs_s1;
    logic                crs_s2;
    logic                crs_s3;
    logic [2:0]          cnt;
    rpc_pkg::rpc_state_t state;
    wire                 crs_rise = crs_s2 & ~crs_s3;
    wire                 busy     = crs_s2 | bp_active;
    // Delay counts only at 100 Mbit/s; at 10 Mbit/s start follows carrier at once
    wire                 no_wait  = ~speed_100 | (delay == 3'h0); // R5

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            crs_s1 <= 1'b0;
            crs_s2 <= 1'b0;
            crs_s3 <= 1'b0;
        end else begin
            crs_s1 <= crs_pin;
            crs_s2 <= crs_s1;
            crs_s3 <= crs_s2;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state          <= rpc_pkg::RPC_IDLE;
            cnt            <= 3'h0;
            preamble_start <= 1'b0;
        end else if (soft_rst) begin
            state          <= rpc_pkg::RPC_IDLE; // R1
            cnt            <= 3'h0;
            preamble_start <= 1'b0;
        end else begin
            preamble_start <= 1'b0;
            case (state)
                rpc_pkg::RPC_IDLE: begin
                    if (crs_rise && no_wait) begin
                        preamble_start <= 1'b1;
                    end else if (crs_rise) begin
                        cnt   <= delay - 3'h1; // R2 R3
                        state <= rpc_pkg::RPC_WAIT;
                    end
                end
                rpc_pkg::RPC_WAIT: begin
                    // Carrier lost before the delay ran out: no preamble
                    if (!crs_s2) begin
                        state <= rpc_pkg::RPC_IDLE;
                    end else if (cnt == 3'h0) begin
                        preamble_start <= 1'b1; // R2
                        state          <= rpc_pkg::RPC_IDLE;
                    end else begin
                        cnt <= cnt - 3'h1;
                    end
                end
                default: state <= rpc_pkg::RPC_IDLE;
            endcase
        end
    end

    // Enables follow the config only between frames so no frame is cut
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tx_path_en <= 1'b0;
            rx_path_en <= 1'b0;
        end else if (soft_rst) begin
            tx_path_en <= 1'b0; // R1
            rx_path_en <= 1'b0;
        end else if (!busy) begin
            tx_path_en <= tx_en_cfg; // R6
            rx_path_en <= rx_en_cfg; // R7
        end
    end

    property p_start_delay4;
        @(posedge ref_clk) disable iff (!nrst)
        (crs_rise && speed_100 && delay == 3'h4 && !soft_rst && state == rpc_pkg::RPC_IDLE)
            ##1 (crs_s2 && !soft_rst)[*4] |=> preamble_start;
    endproperty
    a_start_delay4: assert property (p_start_delay4) else $error("preamble start not delay plus one"); // R3

    property p_no_early_start;
        @(posedge ref_clk) disable iff (!nrst)
        (crs_rise && speed_100 && delay == 3'h4 && state == rpc_pkg::RPC_IDLE) |=> !preamble_start[*4];
    endproperty
    a_no_early_start: assert property (p_no_early_start) else $error("preamble started early"); // R2

    property p_ten_mode_immediate;
        @(posedge ref_clk) disable iff (!nrst)
        (crs_rise && !speed_100 && !soft_rst && state == rpc_pkg::RPC_IDLE) |=> preamble_start;
    endproperty
    a_ten_mode_immediate: assert property (p_ten_mode_immediate) else $error("delay used in 10M mode"); // R5

    property p_tx_change_idle;
        @(posedge ref_clk) disable iff (!nrst)
        $changed(tx_path_en) |-> $past(!busy || soft_rst);
    endproperty
    a_tx_change_idle: assert property (p_tx_change_idle) else $error("tx enable changed mid activity"); // R6

    property p_rx_change_idle;
        @(posedge ref_clk) disable iff (!nrst)
        $changed(rx_path_en) |-> $past(!busy || soft_rst);
    endproperty
    a_rx_change_idle: assert property (p_rx_change_idle) else $error("rx enable changed mid activity"); // R7
endmodule

// >>> rtl/rpc_top.sv
// Local design decision: register access over APB.
`timescale 1ns/1ps
module rpc_top (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        speed_100_pin,
    input  wire logic [1:0]  crs_pin,
    input  wire logic [1:0]  bp_active,
    output logic      [1:0]  port_logic_rst,
    output logic      [1:0]  preamble_start,
    output logic      [1:0]  tx_path_en,
    output logic      [1:0]  rx_path_en,
    output logic      [1:0]  autopart_en,
    output logic      [1:0]  rx_dv_used
);
    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic        spd_s1;
    logic        speed_100;
    logic [1:0]  soft_rst;
    logic [5:0]  delay;
    logic [1:0]  rx_valid_present;
    logic [1:0]  port_tx_enable;
    logic [1:0]  port_rx_enable;
    logic [1:0]  autopartition_disable;
    logic [31:0] next_prdata;
    logic        mapped;

    wire setup     = psel & ~penable;
    wire access_wr = psel & penable & pwrite;
    wire hit_ctl0  = (paddr == rpc_pkg::RPC_PORT0_CONTROL_ADDR);
    wire hit_cfg0  = (paddr == rpc_pkg::RPC_PORT0_CONFIG_A_ADDR);
    wire hit_ctl1  = (paddr == rpc_pkg::RPC_PORT1_CONTROL_ADDR);
    wire hit_cfg1  = (paddr == rpc_pkg::RPC_PORT1_CONFIG_A_ADDR);
    wire [1:0] hit_ctl = {hit_ctl1, hit_ctl0};
    wire [1:0] hit_cfg = {hit_cfg1, hit_cfg0};

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign mapped  = hit_ctl0 | hit_cfg0 | hit_ctl1 | hit_cfg1;

    function automatic logic [31:0] rpc_cfg_word(input logic [2:0] d, input logic v, input logic t,
                                                 input logic r, input logic a);
        logic [31:0] w;
        w = 32'h0;
        w[rpc_pkg::RPC_DELAY_LSB +: 3]       = d;
        w[rpc_pkg::RPC_RX_VALID_BIT]         = v;
        w[rpc_pkg::RPC_TX_EN_BIT]            = t;
        w[rpc_pkg::RPC_RX_EN_BIT]            = r;
        w[rpc_pkg::RPC_AUTOPART_DIS_BIT]     = a;
        return w;
    endfunction

    always_comb begin
        next_prdata = 32'h0;
        if (hit_ctl0) begin
            next_prdata[rpc_pkg::RPC_SOFT_RESET_BIT] = soft_rst[0];
        end else if (hit_cfg0) begin
            next_prdata = rpc_cfg_word(delay[2:0], rx_valid_present[0], port_tx_enable[0],
                                       port_rx_enable[0], autopartition_disable[0]);
        end else if (hit_ctl1) begin
            next_prdata[rpc_pkg::RPC_SOFT_RESET_BIT] = soft_rst[1];
        end else if (hit_cfg1) begin
            next_prdata = rpc_cfg_word(delay[5:3], rx_valid_present[1], port_tx_enable[1],
                                       port_rx_enable[1], autopartition_disable[1]);
        end
    end

    // Read data is captured in the setup cycle so the access phase needs no wait
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0;
        end else if (setup && !pwrite) begin
            prdata <= next_prdata;
        end
    end

    // ------------------------------------------------------------
    // Speed pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            spd_s1    <= 1'b0;
            speed_100 <= 1'b0;
        end else begin
            spd_s1    <= speed_100_pin;
            speed_100 <= spd_s1;
        end
    end

    // ------------------------------------------------------------
    // Per-port registers and logic
    // ------------------------------------------------------------
    for (genvar i = 0; i < rpc_pkg::RPC_PORTS; i++) begin : g_port
        // Soft reset self-clears after one cycle so software need not write 0 back
        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                soft_rst[i] <= rpc_pkg::RPC_FLAG_RESET; // R1
            end else begin
                soft_rst[i] <= access_wr & hit_ctl[i] & pwdata[rpc_pkg::RPC_SOFT_RESET_BIT]; // R1
            end
        end

        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                delay[3*i +: 3]          <= rpc_pkg::RPC_DELAY_RESET; // R4
                rx_valid_present[i]      <= rpc_pkg::RPC_FLAG_RESET;
                port_tx_enable[i]        <= rpc_pkg::RPC_FLAG_RESET;
                port_rx_enable[i]        <= rpc_pkg::RPC_FLAG_RESET;
                autopartition_disable[i] <= rpc_pkg::RPC_FLAG_RESET;
            end else if (access_wr && hit_cfg[i]) begin
                delay[3*i +: 3]          <= pwdata[rpc_pkg::RPC_DELAY_LSB +: 3]; // R3
                rx_valid_present[i]      <= pwdata[rpc_pkg::RPC_RX_VALID_BIT];
                port_tx_enable[i]        <= pwdata[rpc_pkg::RPC_TX_EN_BIT];
                port_rx_enable[i]        <= pwdata[rpc_pkg::RPC_RX_EN_BIT];
                autopartition_disable[i] <= pwdata[rpc_pkg::RPC_AUTOPART_DIS_BIT];
            end
        end

        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                autopart_en[i] <= 1'b1;
                rx_dv_used[i]  <= 1'b0;
            end else begin
                autopart_en[i] <= ~autopartition_disable[i]; // R8
                rx_dv_used[i]  <= rx_valid_present[i] & ~speed_100; // R9
            end
        end

        rpc_port i_rpc_port (
            .ref_clk        (ref_clk),
            .nrst           (nrst),
            .soft_rst       (soft_rst[i]),
            .speed_100      (speed_100),
            .crs_pin        (crs_pin[i]),
            .bp_active      (bp_active[i]),
            .delay          (delay[3*i +: 3]),
            .tx_en_cfg      (port_tx_enable[i]),
            .rx_en_cfg      (port_rx_enable[i]),
            .preamble_start (preamble_start[i]),
            .tx_path_en     (tx_path_en[i]),
            .rx_path_en     (rx_path_en[i])
        );
    end

    assign port_logic_rst = soft_rst;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_soft_reset_pulse;
        @(posedge ref_clk) disable iff (!nrst)
        (access_wr && hit_ctl0 && pwdata[0]) |=> port_logic_rst[0] ##1 !port_logic_rst[0] || $past(access_wr);
    endproperty
    a_soft_reset_pulse: assert property (p_soft_reset_pulse) else $error("port 0 soft reset not a pulse"); // R1

    property p_soft_reset_clears;
        @(posedge ref_clk) disable iff (!nrst)
        port_logic_rst[0] |=> !tx_path_en[0] && !rx_path_en[0];
    endproperty
    a_soft_reset_clears: assert property (p_soft_reset_clears) else $error("soft reset left enables set"); // R1

    property p_delay_write;
        @(posedge ref_clk) disable iff (!nrst)
        (access_wr && hit_cfg1) |=> delay[5:3] == $past(pwdata[14:12]);
    endproperty
    a_delay_write: assert property (p_delay_write) else $error("delay field not stored"); // R3

    property p_delay_reset;
        @(posedge ref_clk)
        $rose(nrst) |-> delay == 6'h24;
    endproperty
    a_delay_reset: assert property (p_delay_reset) else $error("delay reset value wrong"); // R4

    property p_autopart;
        @(posedge ref_clk) disable iff (!nrst)
        (access_wr && hit_cfg0) |=> ##1 autopart_en[0] == !$past(pwdata[6], 2);
    endproperty
    a_autopart: assert property (p_autopart) else $error("autopartition control wrong"); // R8

    property p_rx_dv_ten;
        @(posedge ref_clk) disable iff (!nrst)
        rx_dv_used[1] |-> $past(!speed_100 && rx_valid_present[1]);
    endproperty
    a_rx_dv_ten: assert property (p_rx_dv_ten) else $error("rx valid used outside 10M mode"); // R9

    property p_tx_gate;
        @(posedge ref_clk) disable iff (!nrst)
        (!port_tx_enable[0] && !bp_active[0] && !port_logic_rst[0])[*4] |=> !tx_path_en[0] || crs_pin[0];
    endproperty
    a_tx_gate: assert property (p_tx_gate) else $error("tx path open while disabled"); // R6

    property p_unmapped;
        @(posedge ref_clk) disable iff (!nrst)
        (psel && penable && !mapped) |-> pslverr && pready;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");
endmodule

// >>> tb/rpc_phy_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Far side: carrier from the PHY, activity from the backplane
// ------------------------------------------------------------
module rpc_phy_model (
    input  wire logic       ref_clk,
    output logic      [1:0] crs_pin,
    output logic      [1:0] bp_active
);
    // Both lines idle low; carrier only stands for the length of a frame
    initial begin
        crs_pin   = 2'h0;
        bp_active = 2'h0;
    end

    task automatic carrier(input int p, input int n);
        crs_pin[p] <= 1'b1;
        repeat (n) @(posedge ref_clk);
        crs_pin[p] <= 1'b0;
    endtask

    task automatic busy(input int p, input logic v);
        bp_active[p] <= v;
    endtask
endmodule

// >>> tb/rpc_top_tb.sv
`timescale 1ns/1ps
module rpc_top_tb;
    logic        ref_clk;
    logic        nrst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        speed_100_pin;
    logic [1:0]  crs_pin;
    logic [1:0]  bp_active;
    logic [1:0]  port_logic_rst;
    logic [1:0]  preamble_start;
    logic [1:0]  tx_path_en;
    logic [1:0]  rx_path_en;
    logic [1:0]  autopart_en;
    logic [1:0]  rx_dv_used;
    logic [31:0] rd;
    logic        err;
    int          fail_count;
    int          n_checks;

    rpc_top i_rpc_top (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .speed_100_pin(speed_100_pin), .crs_pin(crs_pin), .bp_active(bp_active),
        .port_logic_rst(port_logic_rst), .preamble_start(preamble_start), .tx_path_en(tx_path_en),
        .rx_path_en(rx_path_en), .autopart_en(autopart_en), .rx_dv_used(rx_dv_used));
    rpc_phy_model i_rpc_phy_model (.ref_clk(ref_clk), .crs_pin(crs_pin), .bp_active(bp_active));

    initial ref_clk = 1'b0;
    always #10 ref_clk = ~ref_clk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One idle cycle follows each transfer so psel is never assigned twice in a step
    // Only the watchdog ends a wait for pready
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        logic [31:0] a [4];
        a = '{rpc_pkg::RPC_PORT0_CONTROL_ADDR, rpc_pkg::RPC_PORT0_CONFIG_A_ADDR,
              rpc_pkg::RPC_PORT1_CONTROL_ADDR, rpc_pkg::RPC_PORT1_CONFIG_A_ADDR};
        chk("autopart after reset", autopart_en, 32'h3);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, a[i], 32'h0);
            chk("reset value", rd, (i % 2) ? 32'h00004000 : 32'h0);
        end
        apb(1'b1, rpc_pkg::RPC_PORT0_CONFIG_A_ADDR, 32'hffffffff);
        apb(1'b0, rpc_pkg::RPC_PORT0_CONFIG_A_ADDR, 32'h0);
        chk("config fields", rd, 32'h000073c0);
        apb(1'b1, rpc_pkg::RPC_PORT0_CONFIG_A_ADDR, 32'h00004000);
        apb(1'b1, 32'he0012028, 32'hffffffff);
        chk("unmapped write err", err, 32'h1);
        apb(1'b0, 32'he0012028, 32'h0);
        chk("unmapped read data", rd, 32'h0);
        $display("test reset done");
    endtask

    // Edges from carrier rise to the start pulse: two sync flops, one register, then the delay
    task automatic t_delay(input int p, input logic [2:0] d, input logic fast, input int exp);
        int cnt;
        speed_100_pin <= fast;
        apb(1'b1, p ? rpc_pkg::RPC_PORT1_CONFIG_A_ADDR : rpc_pkg::RPC_PORT0_CONFIG_A_ADDR, {17'h0, d, 12'h0});
        repeat (5) @(posedge ref_clk);
        cnt = 0;
        fork
            i_rpc_phy_model.carrier(p, 14);
            begin
                do begin
                    @(posedge ref_clk);
                    #1;
                    cnt++;
                end while (preamble_start[p] !== 1'b1 && cnt < 14);
                @(posedge ref_clk);
                #1;
                chk("start pulse width", preamble_start[p], 32'h0);
            end
        join
        chk("preamble delay", cnt, exp);
        repeat (4) @(posedge ref_clk);
    endtask

    task automatic t_delays;
        for (int i = 0; i < 8; i++) t_delay(i % 2, 3'(i), 1'b1, 3 + i);
        t_delay(0, 3'h7, 1'b0, 3);
        $display("test delays done");
    endtask

    task automatic t_enable;
        i_rpc_phy_model.busy(1, 1'b1);
        apb(1'b1, rpc_pkg::RPC_PORT1_CONFIG_A_ADDR, 32'h00004180);
        repeat (4) @(posedge ref_clk);
        chk("tx held while busy", tx_path_en[1], 32'h0);
        chk("rx held while busy", rx_path_en[1], 32'h0);
        i_rpc_phy_model.busy(1, 1'b0);
        repeat (3) @(posedge ref_clk);
        chk("tx on when idle", tx_path_en[1], 32'h1);
        chk("rx on when idle", rx_path_en[1], 32'h1);
        fork
            i_rpc_phy_model.carrier(1, 12);
            begin
                repeat (3) @(posedge ref_clk);
                apb(1'b1, rpc_pkg::RPC_PORT1_CONFIG_A_ADDR, 32'h00004000);
                chk("tx kept in frame", tx_path_en[1], 32'h1);
                chk("rx kept in frame", rx_path_en[1], 32'h1);
            end
        join
        repeat (5) @(posedge ref_clk);
        chk("tx off after frame", tx_path_en[1], 32'h0);
        chk("rx off after frame", rx_path_en[1], 32'h0);
        $display("test enable done");
    endtask

    task automatic t_flags;
        speed_100_pin <= 1'b0;
        apb(1'b1, rpc_pkg::RPC_PORT1_CONFIG_A_ADDR, 32'h00004240);
        repeat (5) @(posedge ref_clk);
        chk("autopart disabled", autopart_en, 32'h1);
        chk("rx valid at 10M", rx_dv_used, 32'h2);
        speed_100_pin <= 1'b1;
        repeat (5) @(posedge ref_clk);
        chk("rx valid at 100M", rx_dv_used, 32'h0);
        $display("test flags done");
    endtask

    task automatic t_soft;
        int hits;
        int drops;
        hits  = 0;
        drops = 0;
        apb(1'b1, rpc_pkg::RPC_PORT0_CONFIG_A_ADDR, 32'h00003180);
        fork
            apb(1'b1, rpc_pkg::RPC_PORT0_CONTROL_ADDR, 32'h1);
            repeat (6) begin
                @(posedge ref_clk);
                #1;
                if (port_logic_rst === 2'h1) hits++;
                if (tx_path_en[0] === 1'b0 && rx_path_en[0] === 1'b0) drops++;
            end
        join
        chk("soft reset pulses", hits, 32'h1);
        chk("soft reset drops enables", drops, 32'h1);
        apb(1'b0, rpc_pkg::RPC_PORT0_CONTROL_ADDR, 32'h0);
        chk("soft reset clears", rd, 32'h0);
        apb(1'b0, rpc_pkg::RPC_PORT0_CONFIG_A_ADDR, 32'h0);
        chk("config kept", rd, 32'h00003180);
        $display("test soft reset done");
    endtask

    initial begin
        #200us;
        fail_count++;
        stop_test();
    end

    initial begin
        fail_count    = 0;
        n_checks      = 0;
        nrst          = 1'b0;
        psel          = 1'b0;
        penable       = 1'b0;
        pwrite        = 1'b0;
        paddr         = 32'h0;
        pwdata        = 32'h0;
        speed_100_pin = 1'b1;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_delays();
        t_enable();
        t_flags();
        t_soft();
        stop_test();
    end
endmodule
